/* File: sim/csq_demod_model.sv */
`default_nettype none
module csq_demod_model #(parameter int ERR_W = 8) (
  // To core
  input wire logic clk,
  output logic lvl_v,
  output logic [7:0] lvl,
  output logic pkt,
  output logic sync,
  output logic sym_v,
  output logic [ERR_W-1:0] sym_err
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {lvl_v, lvl, pkt, sync, sym_v, sym_err} = '0;
  task automatic level(input logic [7:0] v, input logic p);
    @(posedge clk);
    lvl_v <= 1'b1;
    lvl <= v;
    pkt <= p;
    @(posedge clk);
    lvl_v <= 1'b0;
    lvl <= ~v;
  endtask
  // sync then symbols, large errors from k on
  task automatic run(input int n, input int k);
    int i;
    @(posedge clk);
    sync <= 1'b1;
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      sync <= 1'b0;
      sym_v <= 1'b1;
      sym_err <= (i >= k) ? ERR_W'($urandom | 32'h80) : '0;
    end
    @(posedge clk);
    sym_v <= 1'b0;
    sym_err <= ~sym_err;
  endtask
endmodule // csq_demod_model
`default_nettype wire

/* File: sim/csq_properties.sv */
`include "csq_regs.vh"
`default_nettype none
module csq_properties (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // Bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  // Radio
  input wire logic LEVEL_VALID,
  input wire logic IDLE_STROBE,
  input wire logic TRANSMIT_STROBE,
  input wire logic SYNTH_READY_STROBE,
  input wire logic [1:0] RADIO_STATE,
  input wire logic GENERAL_OUTPUT_PIN0,
  input wire logic GENERAL_OUTPUT_PIN1
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  wire in_rx = RADIO_STATE == `CSQ_ST_RX;
  wire no_strb = !TRANSMIT_STROBE && !SYNTH_READY_STROBE && !IDLE_STROBE;
  sequence quiet_s;
    in_rx && !LEVEL_VALID && !WB_CYC_I;
  endsequence
  sequence tx_req_s;
    in_rx && TRANSMIT_STROBE && !SYNTH_READY_STROBE && !IDLE_STROBE;
  endsequence
  sequence fs_req_s;
    in_rx && SYNTH_READY_STROBE && !TRANSMIT_STROBE && !IDLE_STROBE;
  endsequence
  AST_ACK_TAKE: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack late");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  AST_ACK_CAUSE: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack unasked");
  AST_TX_GATE: assert property (tx_req_s |=> RADIO_STATE inside {`CSQ_ST_RX, `CSQ_ST_TX})
    else $error("bad tx move");
  AST_FS_GATE: assert property (fs_req_s |=> RADIO_STATE inside {`CSQ_ST_RX, `CSQ_ST_SYNTH})
    else $error("bad synth move");
  AST_RX_HOLD: assert property (in_rx && no_strb |=> in_rx)
    else $error("left rx alone");
  // Pins may lag the flag by a cycle
  AST_FLAG_HOLD: assert property (quiet_s ##1 quiet_s ##1 in_rx |-> $stable({GENERAL_OUTPUT_PIN0, GENERAL_OUTPUT_PIN1}))
    else $error("pins moved");
  AST_FLAGS_OFF: assert property (!in_rx && !$past(in_rx) && !$past(in_rx, 2) |-> !GENERAL_OUTPUT_PIN0 && !GENERAL_OUTPUT_PIN1)
    else $error("pins high off rx");
endmodule // csq_properties
`default_nettype wire

/* File: sim/tb.sv */
`include "csq_regs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic rxe = 1'b0, idl = 1'b0, txs = 1'b0, syn = 1'b0;
  logic [7:0] adr = '0;
  logic [31:0] wd = '0, q;
  logic [31:0] rv [5] = '{32'h0, 32'h3, 32'h3, 32'he09, 32'h1};
  wire [31:0] rd;
  wire [7:0] ls, sb, se;
  wire [1:0] st;
  wire ack, lv, pk, sf, sv, sse, sap, p0, p1;
  int error_cnt = 0, samples_checked = 0, i, r, s;
  always #12.5 clk = ~clk;
  csq_core u_csq_core (.CLOCK(clk), .SRST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack), .LEVEL_VALID(lv),
    .LEVEL_SAMPLE(ls), .PKT_ACTIVE(pk), .SYNC_FOUND(sf), .SYMBOL_VALID(sv), .SYMBOL_ERR(se), .RX_ENTER(rxe),
    .IDLE_STROBE(idl), .TRANSMIT_STROBE(txs), .SYNTH_READY_STROBE(syn), .RADIO_STATE(st),
    .SYNC_SEARCH_EN(sse), .STATUS_APPEND(sap), .STATUS_BYTE(sb), .GENERAL_OUTPUT_PIN0(p0),
    .GENERAL_OUTPUT_PIN1(p1));
  csq_demod_model u_demod (.clk(clk), .lvl_v(lv), .lvl(ls), .pkt(pk), .sync(sf), .sym_v(sv), .sym_err(se));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    // Hold the request until ack is seen at a rising edge
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    {cyc, stb} <= 2'b00;
  endtask
  // Strobe bits: rx, idle, tx, synth
  task automatic strb(input logic [3:0] m);
    @(posedge clk);
    {rxe, idl, txs, syn} <= m;
    @(posedge clk);
    {rxe, idl, txs, syn} <= 4'h0;
    @(negedge clk);
  endtask
  task automatic lev(input logic [7:0] v, input logic p);
    u_demod.level(v, p);
    repeat (4) @(posedge clk);
    wb(0, `CSQ_ADDR_PKT_STATE, 0);
  endtask
  function automatic logic exp_clr(input logic [1:0] m, input logic cs, input logic pa);
    return (!m[0] || !cs) && (!m[1] || !pa);
  endfunction
  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run;
  end
  initial begin
    s = $urandom(41);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 5; i++) begin
      wb(0, 8'(i * 4), 0);
      chk(q, rv[i]);
    end
    wb(1, 8'h24, 32'hff);
    wb(0, 8'h24, 0);
    chk(q, 0);
    wb(1, `CSQ_ADDR_PKT_CTRL, 32'h3);
    strb(4'h8);
    // Extreme levels sit far off any threshold
    for (i = 0; i < 8; i++) begin
      r = $urandom % 2;
      wb(1, `CSQ_ADDR_SM_CFG, i % 4);
      lev(i > 3 ? 8'h7f : 8'h80, r[0]);
      s = exp_clr(i[1:0], i > 3, r[0]);
      chk(q[1], i > 3);
      chk(p1, i > 3);
      chk(sse, i > 3);
      chk(q[2], s);
      chk(p0, s);
      strb(4'h2);
      chk(st, s ? `CSQ_ST_TX : `CSQ_ST_RX);
      if (s) begin
        strb(4'h4);
        strb(4'h8);
      end else begin
        lev(8'h80, 1'b0);
        chk(st, `CSQ_ST_RX);
      end
    end
    wb(1, `CSQ_ADDR_SM_CFG, 0);
    strb(4'h1);
    chk(st, `CSQ_ST_SYNTH);
    strb(4'h4);
    strb(4'h8);
    // host leaves both amp gains alone; only the step field moves
    for (r = 1; r < 4; r++) begin
      wb(1, `CSQ_ADDR_GAIN_ONE, r << 4);
      s = r * 8 + 4;
      lev(8'h9c, 1'b0);
      lev(8'(8'h9c + s - 1), 1'b0);
      chk(q[1], 0);
      lev(8'(8'h9c + 2 * s), 1'b0);
      chk(q[1], 1);
      lev(8'(8'h9c + s - 1), 1'b0);
      chk(q[1], 0);
    end
    wb(1, `CSQ_ADDR_GAIN_ONE, 0);
    lev(8'hd0, 1'b0);
    wb(0, `CSQ_ADDR_SIG_LEVEL, 0);
    chk(q, 32'hd0);
    u_demod.run(72, 64);
    repeat (4) @(posedge clk);
    wb(0, `CSQ_ADDR_LINK_QUAL, 0);
    chk(q, 32'hff);
    chk(sb, 8'hff);
    chk(sap, 1);
    lev(8'h10, 1'b0);
    wb(0, `CSQ_ADDR_SIG_LEVEL, 0);
    chk(q, 32'hd0);
    u_demod.run(64, 0);
    repeat (4) @(posedge clk);
    wb(0, `CSQ_ADDR_LINK_QUAL, 0);
    chk(q < 32'hff, 1);
    complete_run;
  end
endmodule // tb
bind csq_core csq_properties u_csq_properties (.CLOCK(CLOCK), .SRST(SRST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .LEVEL_VALID(LEVEL_VALID), .IDLE_STROBE(IDLE_STROBE),
  .TRANSMIT_STROBE(TRANSMIT_STROBE), .SYNTH_READY_STROBE(SYNTH_READY_STROBE), .RADIO_STATE(RADIO_STATE),
  .GENERAL_OUTPUT_PIN0(GENERAL_OUTPUT_PIN0), .GENERAL_OUTPUT_PIN1(GENERAL_OUTPUT_PIN1));
`default_nettype wire

/* File: src/csq_core.v */
// Functional notes
// - Absolute sense flag sets above threshold, clears below, with hysteresis.
// - Relative mode: rise by step sets, fall by step clears the flag.
// - Relative step field: off, 6 dB, 10 dB or 14 dB.
// - Absolute offset shifts threshold by -8 dB to +7 dB in 1 dB steps.
// - Threshold derives from both amp gains, offset and magnitude goal.
// - If sense qualifies sync, sync search runs only while sense is high.
// - Sense flag on pins selected with 14 and in packet status bit.
// - Clear channel state on pins selected with 0x09.
// - Transmit strobes in receive succeed only when channel is clear.
// - Rejected strobe is dropped; host must strobe again later.
// - Rule: always, level below threshold, no packet, or both.
// - Link quality accumulates error magnitude over 64 symbols after sync.
// - Link quality goes to last status byte and a status register.
// - Larger link quality value means better link, same modulation only.
// - Signal level is two's complement in half-dB steps.
// - Signal level report freezes after sync until receive entered again.
`include "csq_regs.vh"
`default_nettype none
module csq_core #(
  parameter ERR_W = 8
) (
  // Clock and reset
  input wire CLOCK,
  input wire SRST,
  // Wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  // Demodulator chain (same clock)
  input wire LEVEL_VALID,
  input wire [7:0] LEVEL_SAMPLE,
  input wire PKT_ACTIVE,
  input wire SYNC_FOUND,
  input wire SYMBOL_VALID,
  input wire [ERR_W-1:0] SYMBOL_ERR,
  // Radio control
  input wire RX_ENTER,
  input wire IDLE_STROBE,
  input wire TRANSMIT_STROBE,
  input wire SYNTH_READY_STROBE,
  output reg [1:0] RADIO_STATE,
  output reg SYNC_SEARCH_EN,
  // Status append
  output reg STATUS_APPEND,
  output reg [7:0] STATUS_BYTE,
  // General output pins
  output reg GENERAL_OUTPUT_PIN0,
  output reg GENERAL_OUTPUT_PIN1
);
  reg [7:0] gain_one_r;
  reg [7:0] gain_two_r;
  reg [7:0] sm_cfg_r;
  reg [15:0] pin_cfg_r;
  reg [7:0] pkt_ctrl_r;
  reg sense_r;
  reg clear_r;
  reg [7:0] level_r;
  reg [7:0] prev_level_r;
  reg have_prev_r;
  reg frozen_r;
  reg lq_run_r;
  reg [6:0] lq_cnt_r;
  reg [ERR_W+5:0] lq_acc_r;
  reg [7:0] lq_r;
  reg sense_nxt;
  reg [7:0] abs_thr;
  reg [7:0] rel_step;
  wire in_rx = (RADIO_STATE == `CSQ_ST_RX);
  wire signed [7:0] lvl = LEVEL_SAMPLE;
  wire signed [7:0] prev = prev_level_r;
  wire signed [8:0] delta = {lvl[7], lvl} - {prev[7], prev};
  wire [1:0] rel_sel = gain_one_r[`CSQ_REL_HI:`CSQ_REL_LO];
  wire [1:0] cca_rule = sm_cfg_r[`CSQ_CCA_HI:`CSQ_CCA_LO];
  wire req = TRANSMIT_STROBE | SYNTH_READY_STROBE;
  wire [7:0] offs = {{4{gain_one_r[`CSQ_ABS_HI]}}, gain_one_r[`CSQ_ABS_HI:`CSQ_ABS_LO]};
  wire [7:0] famp = {5'h00, gain_two_r[`CSQ_FAMP_HI:`CSQ_FAMP_LO]};
  wire [7:0] damp = {6'h00, gain_two_r[`CSQ_DAMP_HI:`CSQ_DAMP_LO]};
  wire [7:0] magn = {5'h00, gain_two_r[`CSQ_MAG_HI:`CSQ_MAG_LO]};
  wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wb_wr = wb_req & WB_WE_I;
  reg clear_nxt;

  // Threshold from gains, offset, goal
  // threshold composition
  always @* begin
    // offset 1 dB each (two half-dB units)
    abs_thr = `CSQ_BASE_THR + famp * `CSQ_FAMP_STEP + damp * `CSQ_DAMP_STEP
      + magn * `CSQ_MAG_STEP + {offs[6:0], 1'b0};
    abs_thr = (8'h00 - 8'h80) + abs_thr;
  end

  always @* begin
    case (rel_sel)
      2'h1: rel_step = `CSQ_REL_6DB;
      2'h2: rel_step = `CSQ_REL_10DB;
      2'h3: rel_step = `CSQ_REL_14DB;
      default: rel_step = 8'h00;
    endcase
  end

  // Sense decision on each new sample
  always @* begin
    sense_nxt = sense_r;
    if ($signed(lvl) > $signed(abs_thr) + `CSQ_HYST)
      sense_nxt = 1'b1;
    else if ($signed(lvl) < $signed(abs_thr) - `CSQ_HYST)
      sense_nxt = 1'b0;
    if (rel_sel != `CSQ_REL_OFF && have_prev_r) begin
      if (delta >= $signed({1'b0, rel_step}))
        sense_nxt = 1'b1;
      else if (delta <= -$signed({1'b0, rel_step}))
        sense_nxt = 1'b0;
    end
  end

  always @* begin
    case (cca_rule)
      `CSQ_CCA_ALWAYS: clear_nxt = 1'b1;
      `CSQ_CCA_LEVEL: clear_nxt = ~sense_nxt;
      `CSQ_CCA_NOPKT: clear_nxt = ~PKT_ACTIVE;
      default: clear_nxt = ~sense_nxt & ~PKT_ACTIVE;
    endcase
  end

  always @(posedge CLOCK) begin
    if (SRST || !in_rx) begin
      sense_r <= 1'b0;
      clear_r <= 1'b0;
      have_prev_r <= 1'b0;
      prev_level_r <= 8'h00;
    end else if (LEVEL_VALID) begin
      sense_r <= sense_nxt;
      clear_r <= clear_nxt;
      prev_level_r <= LEVEL_SAMPLE;
      have_prev_r <= 1'b1;
    end
  end

  always @(posedge CLOCK) begin
    if (SRST) begin
      level_r <= 8'h80;
      frozen_r <= 1'b0;
    end else begin
      if (RX_ENTER)
        frozen_r <= 1'b0;
      else if (SYNC_FOUND && SYNC_SEARCH_EN)
        frozen_r <= 1'b1;
      if (in_rx && LEVEL_VALID && !frozen_r && !(SYNC_FOUND && SYNC_SEARCH_EN))
        level_r <= LEVEL_SAMPLE;
    end
  end

  always @(posedge CLOCK) begin
    if (SRST) begin
      lq_run_r <= 1'b0;
      lq_cnt_r <= 7'h00;
      lq_acc_r <= {(ERR_W+6){1'b0}};
      lq_r <= 8'h00;
    end else if (SYNC_FOUND && in_rx) begin
      lq_run_r <= 1'b1;
      lq_cnt_r <= 7'h00;
      lq_acc_r <= {(ERR_W+6){1'b0}};
    end else if (lq_run_r && SYMBOL_VALID) begin
      lq_acc_r <= lq_acc_r + {6'h00, SYMBOL_ERR};
      lq_cnt_r <= lq_cnt_r + 7'h01;
      if (lq_cnt_r == `CSQ_LQI_SYMS - 7'h01) begin
        lq_run_r <= 1'b0;
        // invert mean error, larger is better
        lq_r <= 8'hff - lq_acc_r[ERR_W+5:ERR_W-2];
      end
    end
  end

  // Radio state with strobes
  always @(posedge CLOCK) begin
    if (SRST) begin
      RADIO_STATE <= `CSQ_ST_IDLE;
    end else if (IDLE_STROBE) begin
      RADIO_STATE <= `CSQ_ST_IDLE;
    end else if (RX_ENTER) begin
      RADIO_STATE <= `CSQ_ST_RX;
    end else if (req) begin
      if (!in_rx || clear_r)
        RADIO_STATE <= TRANSMIT_STROBE ? `CSQ_ST_TX : `CSQ_ST_SYNTH;
    end
  end

  // Outputs
  always @(posedge CLOCK) begin
    if (SRST) begin
      SYNC_SEARCH_EN <= 1'b0;
      STATUS_APPEND <= 1'b0;
      STATUS_BYTE <= 8'h00;
      GENERAL_OUTPUT_PIN0 <= 1'b0;
      GENERAL_OUTPUT_PIN1 <= 1'b0;
    end else begin
      SYNC_SEARCH_EN <= in_rx & (~pkt_ctrl_r[`CSQ_SYNCQ_BIT] | sense_r);
      STATUS_APPEND <= pkt_ctrl_r[`CSQ_APPEND_BIT];
      STATUS_BYTE <= lq_r;
      GENERAL_OUTPUT_PIN0 <= pin_sel(pin_cfg_r[`CSQ_PIN0_HI:`CSQ_PIN0_LO], sense_r, clear_r);
      GENERAL_OUTPUT_PIN1 <= pin_sel(pin_cfg_r[`CSQ_PIN1_HI:`CSQ_PIN1_LO], sense_r, clear_r);
    end
  end

  function pin_sel;
    input [5:0] sel;
    input cs;
    input cc;
    begin
      pin_sel = (sel == `CSQ_PIN_SENSE) ? cs : (sel == `CSQ_PIN_CLEAR) ? cc : 1'b0;
    end
  endfunction

  // Wishbone registers; writes use low byte lanes
  always @(posedge CLOCK) begin
    if (SRST) begin
      gain_one_r <= `CSQ_RST_GAIN_ONE;
      gain_two_r <= `CSQ_RST_GAIN_TWO;
      sm_cfg_r <= `CSQ_RST_SM_CFG;
      pin_cfg_r <= `CSQ_RST_PIN_CFG;
      pkt_ctrl_r <= `CSQ_RST_PKT_CTRL;
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_wr && WB_SEL_I[0]) begin
        case (WB_ADR_I)
          `CSQ_ADDR_GAIN_ONE: gain_one_r <= WB_DAT_I[7:0];
          `CSQ_ADDR_GAIN_TWO: gain_two_r <= WB_DAT_I[7:0];
          `CSQ_ADDR_SM_CFG: sm_cfg_r <= WB_DAT_I[7:0];
          `CSQ_ADDR_PIN_CFG: pin_cfg_r[7:0] <= WB_DAT_I[7:0];
          `CSQ_ADDR_PKT_CTRL: pkt_ctrl_r <= WB_DAT_I[7:0];
          default: ;
        endcase
      end
      if (wb_wr && WB_SEL_I[1] && WB_ADR_I == `CSQ_ADDR_PIN_CFG)
        pin_cfg_r[15:8] <= WB_DAT_I[15:8];
      if (wb_req) begin
        case (WB_ADR_I)
          `CSQ_ADDR_GAIN_ONE: WB_DAT_O <= {24'h000000, gain_one_r};
          `CSQ_ADDR_GAIN_TWO: WB_DAT_O <= {24'h000000, gain_two_r};
          `CSQ_ADDR_SM_CFG: WB_DAT_O <= {24'h000000, sm_cfg_r};
          `CSQ_ADDR_PIN_CFG: WB_DAT_O <= {16'h0000, pin_cfg_r};
          `CSQ_ADDR_PKT_CTRL: WB_DAT_O <= {24'h000000, pkt_ctrl_r};
          `CSQ_ADDR_PKT_STATE: WB_DAT_O <= {28'h0000000, GENERAL_OUTPUT_PIN1, clear_r, sense_r, GENERAL_OUTPUT_PIN0};
          `CSQ_ADDR_SIG_LEVEL: WB_DAT_O <= {24'h000000, level_r};
          `CSQ_ADDR_LINK_QUAL: WB_DAT_O <= {24'h000000, lq_r};
          `CSQ_ADDR_SM_STATE: WB_DAT_O <= {30'h00000000, RADIO_STATE};
          default: WB_DAT_O <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // csq_core
`default_nettype wire

/* File: src/csq_regs.vh */
`ifndef CSQ_REGS_VH
`define CSQ_REGS_VH
// Register byte addresses
`define CSQ_ADDR_GAIN_ONE 8'h00
`define CSQ_ADDR_GAIN_TWO 8'h04
`define CSQ_ADDR_SM_CFG 8'h08
`define CSQ_ADDR_PIN_CFG 8'h0c
`define CSQ_ADDR_PKT_CTRL 8'h10
`define CSQ_ADDR_PKT_STATE 8'h14
`define CSQ_ADDR_SIG_LEVEL 8'h18
`define CSQ_ADDR_LINK_QUAL 8'h1c
`define CSQ_ADDR_SM_STATE 8'h20
// gain_ctrl_one fields: [3:0] abs offset (signed), [5:4] rel step
`define CSQ_ABS_LO 0
`define CSQ_ABS_HI 3
`define CSQ_REL_LO 4
`define CSQ_REL_HI 5
// gain_ctrl_two fields: [2:0] magnitude goal, [5:3] front amp, [7:6] digital amp
`define CSQ_MAG_LO 0
`define CSQ_MAG_HI 2
`define CSQ_FAMP_LO 3
`define CSQ_FAMP_HI 5
`define CSQ_DAMP_LO 6
`define CSQ_DAMP_HI 7
// radio_sm_cfg: [1:0] clear channel rule
`define CSQ_CCA_LO 0
`define CSQ_CCA_HI 1
// pin_cfg_reg: [5:0] pin0 select, [13:8] pin1 select
`define CSQ_PIN0_LO 0
`define CSQ_PIN0_HI 5
`define CSQ_PIN1_LO 8
`define CSQ_PIN1_HI 13
// packet_ctrl_one: [0] status append, [1] sense qualifies sync
`define CSQ_APPEND_BIT 0
`define CSQ_SYNCQ_BIT 1
// Reset values
`define CSQ_RST_GAIN_ONE 8'h00
`define CSQ_RST_GAIN_TWO 8'h03
`define CSQ_RST_SM_CFG 8'h03
`define CSQ_RST_PIN_CFG 16'h0e09
`define CSQ_RST_PKT_CTRL 8'h01
// Encodings
`define CSQ_PIN_SENSE 6'h0e
`define CSQ_PIN_CLEAR 6'h09
`define CSQ_CCA_ALWAYS 2'h0
`define CSQ_CCA_LEVEL 2'h1
`define CSQ_CCA_NOPKT 2'h2
`define CSQ_CCA_BOTH 2'h3
`define CSQ_REL_OFF 2'h0
`define CSQ_REL_6DB 8'sh0c
`define CSQ_REL_10DB 8'sh14
`define CSQ_REL_14DB 8'sh1c
// Level thresholds in half-dB; link quality symbol count
`define CSQ_BASE_THR 8'sh3c
`define CSQ_FAMP_STEP 8'sh06
`define CSQ_DAMP_STEP 8'sh0c
`define CSQ_MAG_STEP 8'sh04
`define CSQ_HYST 8'sh02
`define CSQ_LQI_SYMS 7'h40
// Radio states
`define CSQ_ST_IDLE 2'h0
`define CSQ_ST_RX 2'h1
`define CSQ_ST_TX 2'h2
`define CSQ_ST_SYNTH 2'h3
`endif
